//--- src/rtcc_timer_chain.sv
/*
 rtcc_timer_chain: reloadable tick divider, 32-bit time counter split into
 four byte-wide reloadable sub-timers, interrupt sub-node and an Avalon-MM
 register slave.
 Assumes i_ref_clock is a level synchronous to i_clock and no faster than
 half of it; system status inputs are synchronous as well.
*/
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps

// Functional notes
// - count only while run set; run resets set
// - prescale select divides reference clock by eight
// - only mode switching may cost ticks
// - increment/decrement request replaces next count step
// - increment waits when next step reloads
// - hardware clears adjustment requests when done
// - divider counts up, reloads, raises tick request
// - reload zero divides by two to sixteen
// - divider plus counter form 48-bit counter
// - counter split into reloadable sub-timers
// - each sub-timer overflow raises its alarm
// - all requests merge into one interrupt
// - per-source enable and request flags
// - chain keeps running through idle, power-down
// - software may write divider count directly
// - async mode from select, sleep, unlocked clock without slowdown
// - async mode rejects writes, allows reads
module rtcc_timer_chain (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // counting reference
   input wire logic i_ref_clock,
   // system status
   input wire rtcc_pkg::rtcc_sys_t i_sys,
   // register bus
   input wire rtcc_pkg::rtcc_avs_req_t i_avs,
   output rtcc_pkg::rtcc_avs_rsp_t o_avs,
   // status and interrupt
   output logic o_async_mode,
   output logic o_irq
);

   rtcc_pkg::rtcc_state_t state_reg;
   rtcc_pkg::rtcc_state_t state_next;
   logic async_mode;
   logic count_event;
   logic tick_ovf;
   logic carry;
   logic wr_en;
   logic [rtcc_pkg::SOURCES-1:0] irq_set;
   logic [31:0] rd_word;
   logic [31:0] wr_word;

   ////////////////////////////////////////////////////////////////////////
   // byte-lane merge of a write into the current word
   function automatic logic [31:0] merge(input logic [31:0] old_word,
                                         input logic [31:0] new_word,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old_word;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = new_word[8*b +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // read view of the register map
   always_comb begin
      rd_word = 32'h0000_0000;
      case (i_avs.address)
         rtcc_pkg::OFS_CTRL: begin
            rd_word[rtcc_pkg::CTRL_RUN] = state_reg.run_bit;
            rd_word[rtcc_pkg::CTRL_PRESCALE] = state_reg.prescale_select;
            rd_word[rtcc_pkg::CTRL_DEC] = state_reg.divider_decrement_req;
            rd_word[rtcc_pkg::CTRL_INC] = state_reg.divider_increment_req;
            rd_word[rtcc_pkg::CTRL_ACCESS] = ~async_mode;
         end
         rtcc_pkg::OFS_DIV_RELOAD: begin
            rd_word[15:0] = state_reg.tick_divider_reload;
         end
         rtcc_pkg::OFS_DIV: begin
            rd_word[15:0] = state_reg.tick_divider;
         end
         rtcc_pkg::OFS_COUNT_LOW: begin
            rd_word[15:0] = state_reg.time_count[15:0];
         end
         rtcc_pkg::OFS_COUNT_HIGH: begin
            rd_word[15:0] = state_reg.time_count[31:16];
         end
         rtcc_pkg::OFS_RELOAD_LOW: begin
            rd_word[15:0] = state_reg.time_reload[15:0];
         end
         rtcc_pkg::OFS_RELOAD_HIGH: begin
            rd_word[15:0] = state_reg.time_reload[31:16];
         end
         rtcc_pkg::OFS_IRQ_CTRL: begin
            for (int s = 0; s < rtcc_pkg::SOURCES; s++) begin
               rd_word[2*s] = state_reg.irq_enable[s];
               rd_word[2*s+1] = state_reg.irq_request[s];
            end
         end
         rtcc_pkg::OFS_SYS_CFG: begin
            rd_word[rtcc_pkg::SYS_CSS] = state_reg.clock_source_select;
            rd_word[rtcc_pkg::SYS_ASYNC] = async_mode;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_next = state_reg;
      irq_set = '0;
      tick_ovf = 1'b0;
      carry = 1'b0;
      wr_word = 32'h0000_0000;

      async_mode = state_reg.clock_source_select | i_sys.sleep |
                   (~i_sys.clock_locked & ~i_sys.slowdown);

      state_next.ref_prev = i_ref_clock;
      count_event = 1'b0;
      if (i_ref_clock & ~state_reg.ref_prev & state_reg.run_bit) begin
         if (state_reg.prescale_select) begin
            state_next.prescale_count =
               state_reg.prescale_count + 1'b1;
            count_event =
               (state_reg.prescale_count == rtcc_pkg::PRESCALE_LAST);
         end else begin
            count_event = 1'b1;
         end
      end

      // no power mode input stops counting
      // single clock domain, no reference edge dropped
      if (count_event) begin
         if (state_reg.divider_decrement_req) begin
            state_next.tick_divider = state_reg.tick_divider - 1'b1;
            state_next.divider_decrement_req = 1'b0;
         end else if (state_reg.divider_increment_req &&
                      state_reg.tick_divider != rtcc_pkg::DIV_ALL_ONES)
         begin
            state_next.tick_divider = state_reg.tick_divider + 1'b1;
            state_next.divider_increment_req = 1'b0;
         end else if (state_reg.tick_divider == rtcc_pkg::DIV_ALL_ONES)
         begin
            state_next.tick_divider = state_reg.tick_divider_reload;
            tick_ovf = 1'b1;
         end else begin
            state_next.tick_divider = state_reg.tick_divider + 1'b1;
         end
      end
      irq_set[0] = tick_ovf;

      carry = tick_ovf;
      for (int t = 0; t < rtcc_pkg::SUB_TIMERS; t++) begin
         if (carry) begin
            if (state_reg.time_count[8*t +: 8] == rtcc_pkg::SUB_ALL_ONES)
            begin
               state_next.time_count[8*t +: 8] =
                  state_reg.time_reload[8*t +: 8];
               irq_set[t+1] = 1'b1;
            end else begin
               state_next.time_count[8*t +: 8] =
                  state_reg.time_count[8*t +: 8] + 8'h01;
               carry = 1'b0;
            end
         end
      end

      state_next.irq_request = state_reg.irq_request | irq_set;

      // bus handshake: one wait cycle, data and effect at the ack edge
      state_next.ack = (i_avs.read | i_avs.write) & ~state_reg.ack;
      if (i_avs.read & ~state_reg.ack) begin
         state_next.readdata = rd_word;
      end
      wr_en = i_avs.write & state_reg.ack & ~async_mode;
      wr_word = merge(rd_word, i_avs.writedata, i_avs.byteenable);
      if (wr_en) begin
         case (i_avs.address)
            rtcc_pkg::OFS_CTRL: begin
               state_next.run_bit = wr_word[rtcc_pkg::CTRL_RUN];
               state_next.prescale_select =
                  wr_word[rtcc_pkg::CTRL_PRESCALE];
               state_next.divider_decrement_req =
                  wr_word[rtcc_pkg::CTRL_DEC];
               state_next.divider_increment_req =
                  wr_word[rtcc_pkg::CTRL_INC];
            end
            rtcc_pkg::OFS_DIV_RELOAD: begin
               state_next.tick_divider_reload = wr_word[15:0];
            end
            rtcc_pkg::OFS_DIV: begin
               state_next.tick_divider = wr_word[15:0];
            end
            rtcc_pkg::OFS_COUNT_LOW: begin
               state_next.time_count[15:0] = wr_word[15:0];
            end
            rtcc_pkg::OFS_COUNT_HIGH: begin
               state_next.time_count[31:16] = wr_word[15:0];
            end
            rtcc_pkg::OFS_RELOAD_LOW: begin
               state_next.time_reload[15:0] = wr_word[15:0];
            end
            rtcc_pkg::OFS_RELOAD_HIGH: begin
               state_next.time_reload[31:16] = wr_word[15:0];
            end
            rtcc_pkg::OFS_IRQ_CTRL: begin
               // software clear, a new event wins
               for (int s = 0; s < rtcc_pkg::SOURCES; s++) begin
                  state_next.irq_enable[s] = wr_word[2*s];
                  state_next.irq_request[s] = wr_word[2*s+1] | irq_set[s];
               end
            end
            rtcc_pkg::OFS_SYS_CFG: begin
               state_next.clock_source_select = wr_word[rtcc_pkg::SYS_CSS];
            end
            default: begin
               state_next.ack = state_next.ack;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         state_reg <= '0;
         state_reg.run_bit <= rtcc_pkg::CTRL_RESET[rtcc_pkg::CTRL_RUN];
         state_reg.prescale_select <=
            rtcc_pkg::CTRL_RESET[rtcc_pkg::CTRL_PRESCALE];
         state_reg.ref_prev <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   always_comb begin
      o_avs.waitrequest = (i_avs.read | i_avs.write) & ~state_reg.ack;
      o_avs.readdata = state_reg.readdata;
      o_async_mode = async_mode;
      o_irq = |(state_reg.irq_request & state_reg.irq_enable);
   end

endmodule

//--- src/rtcc_pkg.sv
/*
 rtcc_pkg: constants, register map and carrier types of the real time
 clock timer chain.
 Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
*/
package rtcc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // bus geometry and register byte offsets
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_DIV_RELOAD = 6'h04;
   localparam logic [5:0] OFS_DIV = 6'h08;
   localparam logic [5:0] OFS_COUNT_LOW = 6'h0C;
   localparam logic [5:0] OFS_COUNT_HIGH = 6'h10;
   localparam logic [5:0] OFS_RELOAD_LOW = 6'h14;
   localparam logic [5:0] OFS_RELOAD_HIGH = 6'h18;
   localparam logic [5:0] OFS_IRQ_CTRL = 6'h1C;
   localparam logic [5:0] OFS_SYS_CFG = 6'h20;

   ////////////////////////////////////////////////////////////////////////
   // clock_control_reg fields and reset value
   localparam int CTRL_RUN = 0;
   localparam int CTRL_PRESCALE = 1;
   localparam int CTRL_DEC = 2;
   localparam int CTRL_INC = 3;
   localparam int CTRL_ACCESS = 15;
   localparam logic [3:0] CTRL_RESET = 4'h3;

   // system_config_two fields
   localparam int SYS_CSS = 0;
   localparam int SYS_ASYNC = 1;

   ////////////////////////////////////////////////////////////////////////
   // chain geometry
   localparam int PRESCALE_DIV = 8;
   localparam int PRESCALE_W = 3;
   localparam logic [PRESCALE_W-1:0] PRESCALE_LAST =
      PRESCALE_W'(PRESCALE_DIV - 1);
   localparam int SUB_TIMERS = 4;
   localparam int SOURCES = SUB_TIMERS + 1;
   localparam logic [15:0] DIV_ALL_ONES = 16'hFFFF;
   localparam logic [7:0] SUB_ALL_ONES = 8'hFF;

   ////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } rtcc_avs_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } rtcc_avs_rsp_t;

   typedef struct packed {
      logic sleep;
      logic clock_locked;
      logic slowdown;
   } rtcc_sys_t;

   typedef struct packed {
      logic run_bit;
      logic prescale_select;
      logic divider_decrement_req;
      logic divider_increment_req;
      logic clock_source_select;
      logic [15:0] tick_divider_reload;
      logic [15:0] tick_divider;
      logic [31:0] time_count;
      logic [31:0] time_reload;
      logic [SOURCES-1:0] irq_enable;
      logic [SOURCES-1:0] irq_request;
      logic [PRESCALE_W-1:0] prescale_count;
      logic ref_prev;
      logic ack;
      logic [31:0] readdata;
   } rtcc_state_t;

endpackage

//--- tb/rtcc_chain_monitor.sv
/*
 rtcc_chain_monitor: port-level assertions for rtcc_timer_chain.
 Assumes one clock domain and a bus master that holds each request
 until waitrequest is low.
*/
`timescale 1ns/100ps
module rtcc_chain_monitor (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // inputs of the chain
   input wire logic i_ref_clock,
   input wire rtcc_pkg::rtcc_sys_t i_sys,
   input wire rtcc_pkg::rtcc_avs_req_t i_avs,
   // outputs of the chain
   input wire rtcc_pkg::rtcc_avs_rsp_t o_avs,
   input wire logic o_async_mode,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);

   logic req;
   assign req = i_avs.read | i_avs.write;

   ////////////////////////////////////////////////////////////////////////
   a_async_sleep: assert property (i_sys.sleep |-> o_async_mode)
      else $error("sleep did not force async mode");
   a_async_unlock: assert property (
      !i_sys.clock_locked && !i_sys.slowdown |-> o_async_mode)
      else $error("unlocked clock did not force async mode");
   a_wait_first: assert property ($rose(req) |-> o_avs.waitrequest)
      else $error("new request answered without a wait cycle");
   a_wait_one: assert property (
      req && o_avs.waitrequest |=> !o_avs.waitrequest)
      else $error("request waited more than one cycle");
   a_idle_ready: assert property (!req |-> !o_avs.waitrequest)
      else $error("waitrequest high with no request");
   a_rdata_hold: assert property (
      !i_avs.read |=> $stable(o_avs.readdata))
      else $error("read data changed without a read");
   // interrupt only moves after a reference edge or a register write
   a_irq_cause: assert property (
      !$past(i_avs.write) && !($past(i_ref_clock) &&
      !$past(i_ref_clock, 2)) |-> $stable(o_irq))
      else $error("interrupt changed without a cause");
   a_irq_clear: assert property ($fell(o_irq) |-> $past(i_avs.write))
      else $error("interrupt dropped without software write");
   a_irq_rise: assert property (
      $rose(o_irq) |-> $past(i_avs.write) || $past(i_ref_clock))
      else $error("interrupt rose without event");

   ////////////////////////////////////////////////////////////////////////
   c_irq: cover property ($rose(o_irq));
   c_read: cover property (i_avs.read && !o_avs.waitrequest);
   c_async: cover property ($rose(o_async_mode));
endmodule

bind rtcc_timer_chain rtcc_chain_monitor rtcc_chain_monitor_i (
   .i_clock(i_clock),
   .i_nrst(i_nrst),
   .i_ref_clock(i_ref_clock),
   .i_sys(i_sys),
   .i_avs(i_avs),
   .o_avs(o_avs),
   .o_async_mode(o_async_mode),
   .o_irq(o_irq)
);

//--- tb/tb_top.sv
/*
 tb_top: register-level bench for rtcc_timer_chain.
 Assumes one wait state per bus access and the byte map of rtcc_pkg.
*/
`timescale 1ns/100ps
module tb_top;
   logic i_clock;
   logic i_nrst;
   logic i_ref_clock;
   logic o_async_mode;
   logic o_irq;
   rtcc_pkg::rtcc_sys_t sys;
   rtcc_pkg::rtcc_avs_req_t avs;
   rtcc_pkg::rtcc_avs_rsp_t rsp;
   int err_total;
   int check_count;
   logic [31:0] q;

   rtcc_timer_chain rtcc_timer_chain_i (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_ref_clock(i_ref_clock),
      .i_sys(sys),
      .i_avs(avs),
      .o_avs(rsp),
      .o_async_mode(o_async_mode),
      .o_irq(o_irq)
   );

   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // request held until the rising edge that samples waitrequest low;
   // data taken and request released at that same edge
   task automatic acc(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      avs.read <= !w;
      avs.write <= w;
      avs.address <= a;
      avs.writedata <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge i_clock);
         if (rsp.waitrequest === 1'b0) break;
      end
      q = rsp.readdata;
      avs.read <= 1'b0;
      avs.write <= 1'b0;
      if (n == 20) begin
         chk("bus timeout", 32'h1, 32'h0);
         print_verdict();
      end
      // one idle edge so the next request is not assigned in this step
      @(posedge i_clock);
   endtask

   task automatic rdc(input string nm, input logic [5:0] a,
                      input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask

   // one reference rising edge per call round
   // reference kept at a quarter of the bus clock
   task automatic tick(input int n);
      repeat (n) begin
         i_ref_clock <= 1'b1;
         repeat (2) @(posedge i_clock);
         i_ref_clock <= 1'b0;
         repeat (2) @(posedge i_clock);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_nrst = 1'b0;
      i_ref_clock = 1'b0;
      sys = '{sleep: 1'b0, clock_locked: 1'b1, slowdown: 1'b0};
      avs = '0;
      avs.byteenable = 4'hF;
      err_total = 0;
      check_count = 0;
      repeat (2) @(posedge i_clock);
      i_nrst <= 1'b1;
      @(posedge i_clock);
      rdc("ctrl reset", rtcc_pkg::OFS_CTRL, 32'h8003);
      rdc("irq reset", rtcc_pkg::OFS_IRQ_CTRL, 32'h0);
      acc(1'b1, 6'h24, 32'hFFFFFFFF);
      rdc("unmapped", 6'h24, 32'h0);
      tick(7);
      rdc("div pre 7", rtcc_pkg::OFS_DIV, 32'h0);
      tick(1);
      rdc("div pre 8", rtcc_pkg::OFS_DIV, 32'h1);
      acc(1'b1, rtcc_pkg::OFS_CTRL, 32'h1);
      tick(3);
      rdc("div direct", rtcc_pkg::OFS_DIV, 32'h4);
      acc(1'b1, rtcc_pkg::OFS_CTRL, 32'h0);
      tick(3);
      rdc("div stopped", rtcc_pkg::OFS_DIV, 32'h4);
      rdc("irq stopped", rtcc_pkg::OFS_IRQ_CTRL, 32'h0);
      acc(1'b1, rtcc_pkg::OFS_CTRL, 32'h1);
      acc(1'b1, rtcc_pkg::OFS_IRQ_CTRL, 32'h155);
      acc(1'b1, rtcc_pkg::OFS_DIV_RELOAD, 32'hFFFE);
      acc(1'b1, rtcc_pkg::OFS_DIV, 32'hFFFD);
      tick(3);
      rdc("div reload", rtcc_pkg::OFS_DIV, 32'hFFFE);
      rdc("tick request", rtcc_pkg::OFS_IRQ_CTRL, 32'h157);
      chk("irq tick", 32'(o_irq), 32'h1);
      rdc("count carry", rtcc_pkg::OFS_COUNT_LOW, 32'h1);
      acc(1'b1, rtcc_pkg::OFS_IRQ_CTRL, 32'h0);
      chk("irq cleared", 32'(o_irq), 32'h0);
      acc(1'b1, rtcc_pkg::OFS_DIV, 32'hFFFF);
      tick(1);
      rdc("req no enable", rtcc_pkg::OFS_IRQ_CTRL, 32'h2);
      chk("irq masked", 32'(o_irq), 32'h0);
      // divider kept below all ones while adjusting
      acc(1'b1, rtcc_pkg::OFS_DIV, 32'h10);
      acc(1'b1, rtcc_pkg::OFS_CTRL, 32'h9);
      tick(1);
      rdc("div inc", rtcc_pkg::OFS_DIV, 32'h11);
      rdc("inc cleared", rtcc_pkg::OFS_CTRL, 32'h8001);
      acc(1'b1, rtcc_pkg::OFS_CTRL, 32'h5);
      tick(1);
      rdc("div dec", rtcc_pkg::OFS_DIV, 32'h10);
      rdc("dec cleared", rtcc_pkg::OFS_CTRL, 32'h8001);
      // increment requested just before an overflow must wait one event
      acc(1'b1, rtcc_pkg::OFS_DIV, 32'hFFFF);
      acc(1'b1, rtcc_pkg::OFS_CTRL, 32'h9);
      tick(1);
      rdc("inc held", rtcc_pkg::OFS_CTRL, 32'h8009);
      rdc("div held", rtcc_pkg::OFS_DIV, 32'hFFFE);
      tick(1);
      rdc("inc late", rtcc_pkg::OFS_CTRL, 32'h8001);
      acc(1'b1, rtcc_pkg::OFS_RELOAD_LOW, 32'hF0);
      acc(1'b1, rtcc_pkg::OFS_COUNT_LOW, 32'hFF);
      acc(1'b1, rtcc_pkg::OFS_IRQ_CTRL, 32'h4);
      tick(1);
      rdc("sub wrap", rtcc_pkg::OFS_COUNT_LOW, 32'h1F0);
      rdc("sub alarm", rtcc_pkg::OFS_IRQ_CTRL, 32'hE);
      chk("irq alarm", 32'(o_irq), 32'h1);
      acc(1'b1, rtcc_pkg::OFS_DIV_RELOAD, 32'h0);
      acc(1'b1, rtcc_pkg::OFS_DIV, 32'hFFFF);
      tick(1);
      rdc("reload zero", rtcc_pkg::OFS_DIV, 32'h0);
      sys.sleep <= 1'b1;
      acc(1'b1, rtcc_pkg::OFS_DIV, 32'h1234);
      tick(1);
      rdc("async write", rtcc_pkg::OFS_DIV, 32'h1);
      rdc("no access", rtcc_pkg::OFS_CTRL, 32'h1);
      chk("async sleep", 32'(o_async_mode), 32'h1);
      sys <= '{sleep: 1'b0, clock_locked: 1'b0, slowdown: 1'b1};
      @(posedge i_clock);
      chk("slowdown sync", 32'(o_async_mode), 32'h0);
      sys.slowdown <= 1'b0;
      @(posedge i_clock);
      chk("unlocked", 32'(o_async_mode), 32'h1);
      sys.clock_locked <= 1'b1;
      @(posedge i_clock);
      acc(1'b1, rtcc_pkg::OFS_SYS_CFG, 32'h1);
      rdc("source select", rtcc_pkg::OFS_SYS_CFG, 32'h3);
      print_verdict();
   end
endmodule
